// ### inc/t2sr_pkg.sv
// Constants and carrier types for the split-mode timer with auto-reload.
// Assumes one 10 MHz clock and a synchronous active-high reset.
`default_nettype none
package t2sr_pkg;
  localparam logic [7:0] LOW_COUNT_ADDR = 8'hCC;
  localparam logic [7:0] HIGH_COUNT_ADDR = 8'hCD;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [1:0] XCLK_SYS12 = 2'h0;
  localparam logic [1:0] XCLK_RTC8 = 2'h1;
  localparam logic [1:0] XCLK_RESERVED = 2'h2;
  localparam logic [1:0] XCLK_CMP0 = 2'h3;
  localparam int SYS_DIV = 12;
  localparam int RTC_DIV = 8;

  typedef struct packed {
    logic sys12;
    logic rtc8;
    logic cmp_edge;
    logic rtc_edge;
  } t2sr_ticks_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } t2sr_sfr_req_t;
endpackage
`default_nettype wire

// ### logic/t2sr_clk_src.sv
// Tick sources: system clock divided by 12, real-time clock divided by 8, edges.
// Assumes the real-time clock and comparator levels are synchronous to mclk.
`default_nettype none
module t2sr_clk_src #(
  parameter int SYS_DIV = t2sr_pkg::SYS_DIV,
  parameter int RTC_DIV = t2sr_pkg::RTC_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Sampled levels
  input wire logic rtc_level,
  input wire logic cmp0_level,
  // Enables, one cycle each
  output t2sr_pkg::t2sr_ticks_t ticks
);
  // The dividers count in eight bits, so larger ratios cannot be served.
  if (SYS_DIV < 2 || SYS_DIV > 256 || RTC_DIV < 2 || RTC_DIV > 256)
  begin : gen_bad_div
    $error("t2sr_clk_src: divider out of range");
  end

  typedef struct packed {
    logic [7:0] sys_cnt;
    logic [7:0] rtc_cnt;
    logic rtc_prev;
    logic cmp_prev;
  } t2sr_src_state_t;

  t2sr_src_state_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    ticks = '0;
    ticks.rtc_edge = rtc_level & ~s_q.rtc_prev;
    ticks.cmp_edge = cmp0_level & ~s_q.cmp_prev;
    s_d.rtc_prev = rtc_level;
    s_d.cmp_prev = cmp0_level;
    if (s_q.sys_cnt == 8'(SYS_DIV - 1))
    begin
      s_d.sys_cnt = 8'h00;
      ticks.sys12 = 1'b1;
    end
    else
    begin
      s_d.sys_cnt = s_q.sys_cnt + 8'h01;
    end
    if (ticks.rtc_edge)
    begin
      if (s_q.rtc_cnt == 8'(RTC_DIV - 1))
      begin
        s_d.rtc_cnt = 8'h00;
        ticks.rtc8 = 1'b1;
      end
      else
      begin
        s_d.rtc_cnt = s_q.rtc_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ### logic/t2sr_timer.sv
// Timer with split 8-bit auto-reload mode, 16-bit auto-reload mode and capture.
// Assumes control bits arrive as levels and flag clears as one-cycle pulses.
`default_nettype none
module t2sr_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Special function register access to the count bytes
  input wire t2sr_pkg::t2sr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Control bits
  input wire logic split_mode_select,
  input wire logic high_run_control,
  input wire logic high_fast_clock_select,
  input wire logic low_fast_clock_select,
  input wire logic [1:0] external_clock_select,
  input wire logic low_overflow_irq_enable,
  input wire logic capture_enable,
  input wire logic timer_irq_enable,
  input wire logic [7:0] low_reload_value,
  input wire logic [7:0] high_reload_value,
  // Software clears of the flags
  input wire logic high_flag_clear,
  input wire logic low_flag_clear,
  // Clock source levels
  input wire logic rtc_level,
  input wire logic cmp0_level,
  // Status and interrupt
  output logic high_overflow_flag,
  output logic low_overflow_flag,
  output logic [15:0] capture_value,
  output logic irq
);
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic tf_h;
    logic tf_l;
    logic irq;
    logic [7:0] rdata;
    logic [15:0] cap;
  } t2sr_state_t;

  t2sr_state_t s_q, s_d;
  t2sr_pkg::t2sr_ticks_t ticks;

  t2sr_clk_src u_src (
    .mclk(mclk),
    .rst(rst),
    .rtc_level(rtc_level),
    .cmp0_level(cmp0_level),
    .ticks(ticks)
  );

  // The reserved field value gives no ticks, so a half without its fast clock select simply stops.
  function automatic logic sel_tick(input logic fast, input logic [1:0] xclk, input t2sr_pkg::t2sr_ticks_t t);
    if (fast)
    begin
      return 1'b1;
    end
    case (xclk)
      t2sr_pkg::XCLK_SYS12: return t.sys12;
      t2sr_pkg::XCLK_RTC8: return t.rtc8;
      t2sr_pkg::XCLK_CMP0: return t.cmp_edge;
      default: return 1'b0;
    endcase
  endfunction

  logic hi_tick, lo_tick, hi_ovf, lo_ovf, cap_evt;

  always_comb
  begin
    hi_tick = sel_tick(high_fast_clock_select, external_clock_select, ticks);
    lo_tick = sel_tick(low_fast_clock_select, external_clock_select, ticks);
    hi_ovf = 1'b0;
    lo_ovf = 1'b0;
    // Capture measures the comparator against the timer clock, or the real-time clock
    // against the timer clock when external_clock_select picks the comparator.
    cap_evt = capture_enable && !split_mode_select &&
              ((external_clock_select == t2sr_pkg::XCLK_CMP0) ? ticks.rtc_edge : ticks.cmp_edge);
    s_d = s_q;
    if (split_mode_select)
    begin
      if (lo_tick)
      begin
        if (s_q.lo == t2sr_pkg::COUNT_MAX)
        begin
          lo_ovf = 1'b1;
          s_d.lo = low_reload_value;
        end
        else
        begin
          s_d.lo = s_q.lo + 8'h01;
        end
      end
      if (high_run_control && hi_tick)
      begin
        if (s_q.hi == t2sr_pkg::COUNT_MAX)
        begin
          hi_ovf = 1'b1;
          s_d.hi = high_reload_value;
        end
        else
        begin
          s_d.hi = s_q.hi + 8'h01;
        end
      end
    end
    else if (high_run_control && lo_tick)
    begin
      if ({s_q.hi, s_q.lo} == {t2sr_pkg::COUNT_MAX, t2sr_pkg::COUNT_MAX})
      begin
        hi_ovf = 1'b1;
        {s_d.hi, s_d.lo} = {high_reload_value, low_reload_value};
      end
      else
      begin
        {s_d.hi, s_d.lo} = {s_q.hi, s_q.lo} + 16'h0001;
      end
    end
    if (cap_evt)
    begin
      s_d.cap = {s_q.hi, s_q.lo};
      hi_ovf = 1'b1;
    end
    // A software write replaces whatever the count did this cycle.
    if (sfr_req.wr && sfr_req.addr == t2sr_pkg::LOW_COUNT_ADDR)
    begin
      s_d.lo = sfr_req.wdata;
    end
    if (sfr_req.wr && sfr_req.addr == t2sr_pkg::HIGH_COUNT_ADDR)
    begin
      s_d.hi = sfr_req.wdata;
    end
    // Set wins over clear so that no overflow is lost; only software or reset clears.
    s_d.tf_h = hi_ovf | (s_q.tf_h & ~high_flag_clear);
    s_d.tf_l = lo_ovf | (s_q.tf_l & ~low_flag_clear);
    s_d.irq = timer_irq_enable & (s_d.tf_h | (low_overflow_irq_enable & s_d.tf_l));
    case (sfr_req.addr)
      t2sr_pkg::LOW_COUNT_ADDR: s_d.rdata = s_d.lo;
      t2sr_pkg::HIGH_COUNT_ADDR: s_d.rdata = s_d.hi;
      default: s_d.rdata = t2sr_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign high_overflow_flag = s_q.tf_h;
  assign low_overflow_flag = s_q.tf_l;
  assign capture_value = s_q.cap;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

// ### verification/t2sr_chk.sv
// Checker for the split-mode timer: flags, interrupt and count bytes.
// Assumes it is bound onto t2sr_timer.
`default_nettype none
module t2sr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access
  input wire t2sr_pkg::t2sr_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] low_reload_value,
  input wire logic [7:0] high_reload_value,
  // Control
  input wire logic split_mode_select,
  input wire logic high_run_control,
  input wire logic high_fast_clock_select,
  input wire logic low_fast_clock_select,
  input wire logic low_overflow_irq_enable,
  input wire logic timer_irq_enable,
  input wire logic high_flag_clear,
  input wire logic low_flag_clear,
  // Status
  input wire logic high_overflow_flag,
  input wire logic low_overflow_flag,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Reads must hold their address two cycles, since read data lags the address by one.
  sequence lo_rd;
    split_mode_select && low_fast_clock_select && !sfr_req.wr && sfr_req.addr == 8'hCC;
  endsequence
  sequence hi_rd;
    split_mode_select && high_run_control && high_fast_clock_select && !sfr_req.wr && sfr_req.addr == 8'hCD;
  endsequence
  sequence hi_idle;
    split_mode_select && !high_run_control && !sfr_req.wr && sfr_req.addr == 8'hCD;
  endsequence
  irq_follows_a: assert property (
    irq == ($past(timer_irq_enable) && (high_overflow_flag || $past(low_overflow_irq_enable) && low_overflow_flag)))
    else $error("irq wrong");
  hflag_sticky_a: assert property (
    $fell(high_overflow_flag) |-> $past(high_flag_clear || rst)) else $error("high flag lost");
  lflag_sticky_a: assert property (
    $fell(low_overflow_flag) |-> $past(low_flag_clear || rst)) else $error("low flag lost");
  low_counts_a: assert property (
    lo_rd ##1 (lo_rd and (sfr_rdata != 8'hFF)) |=> sfr_rdata == $past(sfr_rdata) + 8'h01) else $error("low stuck");
  low_wrap_a: assert property (
    lo_rd ##1 (lo_rd and (sfr_rdata == 8'hFF)) |=> low_overflow_flag && sfr_rdata == $past(low_reload_value))
    else $error("low wrap");
  high_wrap_a: assert property (
    hi_rd ##1 (hi_rd and (sfr_rdata == 8'hFF)) |=> high_overflow_flag && sfr_rdata == $past(high_reload_value))
    else $error("high wrap");
  high_stop_a: assert property (
    hi_idle ##1 hi_idle |=> $stable(sfr_rdata)) else $error("high ran");
  byte_write_a: assert property (
    sfr_req.wr && (sfr_req.addr == 8'hCC || sfr_req.addr == 8'hCD) |=> sfr_rdata == $past(sfr_req.wdata))
    else $error("write lost");
endmodule
bind t2sr_timer t2sr_chk u_chk (.mclk, .rst, .sfr_req, .sfr_rdata, .low_reload_value, .high_reload_value,
  .split_mode_select, .high_run_control, .high_fast_clock_select, .low_fast_clock_select,
  .low_overflow_irq_enable, .timer_irq_enable, .high_flag_clear, .low_flag_clear, .high_overflow_flag,
  .low_overflow_flag, .irq);
`default_nettype wire

// ### verification/t2sr_timer_test.sv
// Testbench for the split-mode timer.
// Assumes registered outputs and a synchronous reset.
`default_nettype none
module t2sr_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, split = 0, run = 0, hf = 0, lf = 0, lie = 0, tie = 0, hclr = 0, lclr = 0, rtc = 0, cmp = 0;
  logic [1:0] xsel = 2'h0;
  logic [7:0] rdata;
  logic hflag, lflag, irq;
  logic [15:0] cap;
  logic cap_en = 0;
  t2sr_pkg::t2sr_sfr_req_t req = '0;
  int errors = 0, checked = 0, cycles = 0;
  logic [23:0] rows [4] = '{24'hCC5A5A, 24'hCDA5A5, 24'h33C300, 24'hCC0F0F};
  logic [7:0] gain [4] = '{8'h14, 8'h13, 8'h10, 8'h28};
  t2sr_timer u_dut (.mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .split_mode_select(split),
    .high_run_control(run), .high_fast_clock_select(hf), .low_fast_clock_select(lf),
    .external_clock_select(xsel), .low_overflow_irq_enable(lie), .capture_enable(cap_en),
    .timer_irq_enable(tie), .low_reload_value(8'h10), .high_reload_value(8'h20), .high_flag_clear(hclr),
    .low_flag_clear(lclr), .rtc_level(rtc), .cmp0_level(cmp), .high_overflow_flag(hflag),
    .low_overflow_flag(lflag), .capture_value(cap), .irq(irq));
  always #50 mclk = ~mclk;
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Toggling both sources gives a rising edge every second cycle.
  always @(posedge mclk)
  begin
    #10;
    rtc = ~rtc;
    cmp = ~cmp;
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic check(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{a, 1'b1, d};
    step(1);
    req.wr = 1'b0;
  endtask
  initial
  begin
    step(6);
    rst = 0;
    req.addr = 8'hCD;
    step(1);
    check(rdata, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      check(rdata, rows[i][7:0]);
      step(1);
    end
    split = 1;
    lf = 1;
    tie = 1;
    wr(8'hCC, 8'hFE);
    step(1);
    // The clear lands on the wrap edge, so the flag must still set.
    lclr = 1;
    step(1);
    lclr = 0;
    check(rdata, 8'h10);
    check({7'h00, lflag}, 8'h01);
    check({7'h00, irq}, 8'h00);
    lie = 1;
    step(1);
    check({7'h00, irq}, 8'h01);
    check({6'h00, hflag, lflag}, 8'h01);
    lclr = 1;
    step(1);
    lclr = 0;
    check({6'h00, lflag, irq}, 8'h00);
    run = 1;
    hf = 1;
    lie = 0;
    wr(8'hCD, 8'hFE);
    step(2);
    check(rdata, 8'h20);
    check({6'h00, hflag, irq}, 8'h03);
    hf = 0;
    for (int s = 0; s < 4; s++)
    begin
      xsel = s[1:0];
      wr(8'hCD, 8'h10);
      step(48);
      check(rdata, gain[s]);
    end
    run = 0;
    wr(8'hCD, 8'h10);
    step(20);
    check(rdata, 8'h10);
    split = 0;
    hclr = 1;
    wr(8'hCD, 8'hFF);
    hclr = 0;
    step(1);
    wr(8'hCC, 8'hFE);
    check({6'h00, hflag, irq}, 8'h00);
    run = 1;
    step(2);
    check(rdata, 8'h10);
    check({7'h00, hflag}, 8'h01);
    run = 0;
    hclr = 1;
    step(1);
    hclr = 0;
    check({7'h00, hflag}, 8'h00);
    // The count is stopped, so every capture event latches the same word.
    cap_en = 1;
    step(2);
    cap_en = 0;
    check(cap[15:8], 8'h20);
    check(cap[7:0], 8'h10);
    check({7'h00, hflag}, 8'h01);
    rst = 1;
    step(2);
    check(rdata, 8'h00);
    check({5'h00, hflag, lflag, irq}, 8'h00);
    check(cap[15:8], 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
